// [common/psr_defines.svh]
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

`define PSR_TARGET_ADDR 7'h60

`define PSR_CMD_STANDBY 8'h00
`define PSR_CMD_SENSE_AB 8'h03
`define PSR_CMD_SENSE_C 8'h04
`define PSR_CMD_LOW_THR 8'h05
`define PSR_CMD_HIGH_THR 8'h06
`define PSR_CMD_XTALK 8'h07
`define PSR_CMD_AUTOCAL 8'h08
`define PSR_CMD_RESULT 8'hF8
`define PSR_CMD_FLAGS 8'hF9
`define PSR_CMD_IDENT 8'hFA
`define PSR_CMD_AC_RESULT 8'hFB

`define PSR_RST_STANDBY_LOW 8'h01
`define PSR_RST_SENSE_A 8'h01
`define PSR_RST_ZERO8 8'h00
`define PSR_RST_ZERO16 16'h0000

`define PSR_RUN_N_BIT 0
`define PSR_QUICK_BIT 1
`define PSR_MODE_LSB 2
`define PSR_PERS_LSB 4
`define PSR_BIAS_BIT 1
`define PSR_READY_BIT 7

`define PSR_FLAG_AWAY_BIT 0
`define PSR_FLAG_CLOSE_BIT 1
`define PSR_AC_BUSY_BIT 7
`define PSR_AC_SUN_BIT 6

`endif

// [common/psr_pkg.sv]
package psr_pkg;

    typedef enum logic [2:0] {
        PSR_IDLE = 3'b000,
        PSR_ADDR = 3'b001,
        PSR_CMD = 3'b010,
        PSR_WDATA = 3'b011,
        PSR_ACK = 3'b100,
        PSR_RDATA = 3'b101,
        PSR_RACK = 3'b110
    } psr_bus_state_t;

    typedef enum logic [1:0] {
        PSR_IRQ_OFF = 2'b00,
        PSR_IRQ_LEVEL = 2'b01,
        PSR_IRQ_EVENT = 2'b10,
        PSR_IRQ_RSVD = 2'b11
    } psr_irq_mode_t;

endpackage : psr_pkg

// [src/psr_top.sv]
`timescale 1ns/1ps
`include "psr_defines.svh"

module psr_top
    import psr_pkg::*;
#(
    parameter logic [7:0] IDENT_LOW = 8'h5A,  // Arbitrary value
    parameter logic [7:0] IDENT_HIGH = 8'h00, // Arbitrary value
    parameter int RESULT_W = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt pin, open drain
    output logic int_out,
    output logic int_oe,
    // Measurement front end
    input wire logic sample_valid,
    input wire logic [RESULT_W-1:0] sample_data,
    input wire logic [RESULT_W-1:0] autocal_value,
    input wire logic autocal_busy,
    input wire logic sunlight_protect,
    // Settings towards the front end
    output logic measure_enable,
    output logic quick_sample_req,
    output logic [7:0] standby_low,
    output logic [7:0] standby_high,
    output logic [7:0] sense_config_a,
    output logic [7:0] sense_config_b,
    output logic [7:0] sense_config_c,
    output logic [7:0] emitter_current_config,
    output logic [15:0] crosstalk_offset,
    output logic [7:0] autocal_config,
    output logic [7:0] low_power_config
);

    // Pin synchronisers and edge finders
    logic scl_meta_q, scl_sync_q, scl_prev_q;
    logic sda_meta_q, sda_sync_q, sda_prev_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= scl_in;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
            sda_meta_q <= sda_in;
            sda_sync_q <= sda_meta_q;
            sda_prev_q <= sda_sync_q;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_sync_q & ~scl_prev_q;
    assign scl_fall = ~scl_sync_q & scl_prev_q;
    assign bus_start = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
    assign bus_stop = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

    // Register file
    logic [7:0] stby_lo_q, stby_hi_q, cfg_a_q, cfg_b_q, cfg_c_q, emit_q;
    logic [7:0] acal_q, lowpow_q, flags_q;
    logic [15:0] thr_lo_q, thr_hi_q, xtalk_q;
    logic [RESULT_W-1:0] result_q;

    // Bus engine state
    psr_bus_state_t state_q;
    logic [7:0] shreg_q, cmd_q, wlo_q;
    logic [3:0] bit_cnt_q;
    logic rw_q, hi_q, after_addr_q, nack_q, sda_oe_q;
    logic wr_stb_q, rd_flags_q;
    logic [15:0] wr_data_q;
    logic [7:0] tx_byte;

    // Read data for the selected pair and byte
    always_comb begin
        tx_byte = 8'h00;
        unique case (cmd_q)
            `PSR_CMD_STANDBY: tx_byte = hi_q ? stby_hi_q : stby_lo_q;
            `PSR_CMD_SENSE_AB: tx_byte = hi_q ? cfg_b_q : cfg_a_q;
            `PSR_CMD_SENSE_C: tx_byte = hi_q ? emit_q : cfg_c_q;
            `PSR_CMD_LOW_THR: tx_byte = hi_q ? thr_lo_q[15:8] : thr_lo_q[7:0];
            `PSR_CMD_HIGH_THR: tx_byte = hi_q ? thr_hi_q[15:8] : thr_hi_q[7:0];
            `PSR_CMD_XTALK: tx_byte = hi_q ? xtalk_q[15:8] : xtalk_q[7:0];
            `PSR_CMD_AUTOCAL: tx_byte = hi_q ? lowpow_q : acal_q;
            `PSR_CMD_RESULT: begin
                tx_byte = hi_q ? {4'h0, result_q[11:8]} : result_q[7:0];
            end
            `PSR_CMD_FLAGS: tx_byte = hi_q ? flags_q : 8'h00;
            `PSR_CMD_IDENT: tx_byte = hi_q ? IDENT_HIGH : IDENT_LOW;
            `PSR_CMD_AC_RESULT: begin
                if (hi_q) begin
                    tx_byte = {autocal_busy, sunlight_protect, 2'b00, autocal_value[11:8]};
                end else begin
                    tx_byte = autocal_value[7:0];
                end
            end
            default: tx_byte = 8'h00;
        endcase
    end

    // Bus engine: bits are taken on SCL rise, SDA is changed on SCL fall
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PSR_IDLE;
            shreg_q <= 8'h00;
            cmd_q <= 8'h00;
            wlo_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            rw_q <= 1'b0;
            hi_q <= 1'b0;
            after_addr_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_stb_q <= 1'b0;
            rd_flags_q <= 1'b0;
            wr_data_q <= 16'h0000;
        end else begin
            wr_stb_q <= 1'b0;
            rd_flags_q <= 1'b0;
            if (bus_start) begin
                state_q <= PSR_ADDR;
                bit_cnt_q <= 4'h0;
                hi_q <= 1'b0;
                sda_oe_q <= 1'b0;
            end else if (bus_stop) begin
                state_q <= PSR_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (state_q == PSR_ADDR || state_q == PSR_CMD || state_q == PSR_WDATA) begin
                    shreg_q <= {shreg_q[6:0], sda_sync_q};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end else if (state_q == PSR_RACK) begin
                    nack_q <= sda_sync_q;
                    // Low byte went first; the high byte follows
                    hi_q <= ~hi_q;
                end
            end else if (scl_fall) begin
                unique case (state_q)
                    PSR_IDLE: ;
                    PSR_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shreg_q[7:1] == `PSR_TARGET_ADDR) begin
                                sda_oe_q <= 1'b1;
                                rw_q <= shreg_q[0];
                                after_addr_q <= 1'b1;
                                state_q <= PSR_ACK;
                            end else begin
                                state_q <= PSR_IDLE;
                            end
                        end
                    end
                    PSR_CMD: begin
                        if (bit_cnt_q == 4'h8) begin
                            cmd_q <= shreg_q;
                            hi_q <= 1'b0;
                            sda_oe_q <= 1'b1;
                            after_addr_q <= 1'b0;
                            state_q <= PSR_ACK;
                        end
                    end
                    PSR_WDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b1;
                            after_addr_q <= 1'b0;
                            state_q <= PSR_ACK;
                            hi_q <= ~hi_q;
                            // A lone low byte is held and never stored
                            if (!hi_q) begin
                                wlo_q <= shreg_q;
                            end else begin
                                wr_stb_q <= 1'b1;
                                wr_data_q <= {shreg_q, wlo_q};
                            end
                        end
                    end
                    PSR_ACK: begin
                        bit_cnt_q <= 4'h0;
                        if (after_addr_q && rw_q) begin
                            shreg_q <= tx_byte;
                            sda_oe_q <= ~tx_byte[7];
                            bit_cnt_q <= 4'h1;
                            rd_flags_q <= (cmd_q == `PSR_CMD_FLAGS) && hi_q;
                            state_q <= PSR_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= after_addr_q ? PSR_CMD : PSR_WDATA;
                        end
                    end
                    PSR_RDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b0;
                            state_q <= PSR_RACK;
                        end else begin
                            shreg_q <= {shreg_q[6:0], 1'b0};
                            sda_oe_q <= ~shreg_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    PSR_RACK: begin
                        if (nack_q) begin
                            state_q <= PSR_IDLE;
                        end else begin
                            shreg_q <= tx_byte;
                            sda_oe_q <= ~tx_byte[7];
                            bit_cnt_q <= 4'h1;
                            rd_flags_q <= (cmd_q == `PSR_CMD_FLAGS) && hi_q;
                            state_q <= PSR_RDATA;
                        end
                    end
                    default: state_q <= PSR_IDLE;
                endcase
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;

    // Word writes land here; read-only and unknown codes are acknowledged and dropped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stby_lo_q <= `PSR_RST_STANDBY_LOW;
            stby_hi_q <= `PSR_RST_ZERO8;
            cfg_a_q <= `PSR_RST_SENSE_A;
            cfg_b_q <= `PSR_RST_ZERO8;
            cfg_c_q <= `PSR_RST_ZERO8;
            emit_q <= `PSR_RST_ZERO8;
            thr_lo_q <= `PSR_RST_ZERO16;
            thr_hi_q <= `PSR_RST_ZERO16;
            xtalk_q <= `PSR_RST_ZERO16;
            acal_q <= `PSR_RST_ZERO8;
            lowpow_q <= `PSR_RST_ZERO8;
        end else if (wr_stb_q) begin
            unique case (cmd_q)
                `PSR_CMD_STANDBY: {stby_hi_q, stby_lo_q} <= wr_data_q;
                `PSR_CMD_SENSE_AB: {cfg_b_q, cfg_a_q} <= wr_data_q;
                `PSR_CMD_SENSE_C: {emit_q, cfg_c_q} <= wr_data_q;
                `PSR_CMD_LOW_THR: thr_lo_q <= wr_data_q;
                `PSR_CMD_HIGH_THR: thr_hi_q <= wr_data_q;
                `PSR_CMD_XTALK: xtalk_q <= wr_data_q;
                `PSR_CMD_AUTOCAL: {lowpow_q, acal_q} <= wr_data_q;
                default: ;
            endcase
        end
    end

    // Measurement path
    logic run_ok, eval_q;
    logic [15:0] sample_ext;
    assign run_ok = ~cfg_a_q[`PSR_RUN_N_BIT];
    assign sample_ext = {{(16 - RESULT_W){1'b0}}, sample_data};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= '0;
            eval_q <= 1'b0;
        end else begin
            eval_q <= sample_valid & run_ok;
            if (sample_valid && run_ok) begin
                // Offset saturates at zero rather than wrapping
                if (sample_ext > xtalk_q) begin
                    result_q <= RESULT_W'(sample_ext - xtalk_q);
                end else begin
                    result_q <= '0;
                end
            end
        end
    end

    // Threshold compare with persistence
    logic [15:0] result_ext;
    logic above, below, close_evt, away_evt;
    logic [2:0] need, cnt_hi_q, cnt_lo_q, cnt_hi_inc, cnt_lo_inc;
    assign result_ext = {{(16 - RESULT_W){1'b0}}, result_q};
    assign above = result_ext > thr_hi_q;
    assign below = result_ext < thr_lo_q;
    assign need = {1'b0, cfg_a_q[`PSR_PERS_LSB+1:`PSR_PERS_LSB]} + 3'h1;
    assign cnt_hi_inc = (cnt_hi_q == 3'h7) ? cnt_hi_q : cnt_hi_q + 3'h1;
    assign cnt_lo_inc = (cnt_lo_q == 3'h7) ? cnt_lo_q : cnt_lo_q + 3'h1;
    assign close_evt = eval_q & above & (cnt_hi_inc == need);
    assign away_evt = eval_q & below & (cnt_lo_inc == need);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_hi_q <= 3'h0;
            cnt_lo_q <= 3'h0;
        end else if (!run_ok) begin
            cnt_hi_q <= 3'h0;
            cnt_lo_q <= 3'h0;
        end else if (eval_q) begin
            // A single sample inside the band restarts the count
            cnt_hi_q <= above ? cnt_hi_inc : 3'h0;
            cnt_lo_q <= below ? cnt_lo_inc : 3'h0;
        end
    end

    // While a crossing is being qualified, ask the front end for faster samples
    logic pending_hi, pending_lo;
    assign pending_hi = (cnt_hi_q != 3'h0) && (cnt_hi_q < need);
    assign pending_lo = (cnt_lo_q != 3'h0) && (cnt_lo_q < need);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            quick_sample_req <= 1'b0;
        end else begin
            quick_sample_req <= cfg_a_q[`PSR_QUICK_BIT] & run_ok & (pending_hi | pending_lo);
        end
    end

    // Interrupt flags and pin
    psr_irq_mode_t irq_mode;
    logic level_q;
    assign irq_mode = psr_irq_mode_t'(cfg_a_q[`PSR_MODE_LSB+1:`PSR_MODE_LSB]);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= `PSR_RST_ZERO8;
        end else begin
            // An event in the clearing cycle survives the clear
            for (int i = 0; i < 8; i++) begin
                if (rd_flags_q) begin
                    flags_q[i] <= 1'b0;
                end
            end
            if (irq_mode == PSR_IRQ_EVENT) begin
                if (close_evt) begin
                    flags_q[`PSR_FLAG_CLOSE_BIT] <= 1'b1;
                end
                if (away_evt) begin
                    flags_q[`PSR_FLAG_AWAY_BIT] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= 1'b0;
        end else if (irq_mode != PSR_IRQ_LEVEL) begin
            level_q <= 1'b0;
        end else if (close_evt) begin
            level_q <= 1'b1;
        end else if (away_evt) begin
            level_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_oe <= 1'b0;
        end else begin
            unique case (irq_mode)
                PSR_IRQ_EVENT: int_oe <= |flags_q;
                PSR_IRQ_LEVEL: int_oe <= level_q;
                PSR_IRQ_OFF: int_oe <= 1'b0;
                PSR_IRQ_RSVD: int_oe <= 1'b0;
            endcase
        end
    end
    assign int_out = 1'b0;

    // Settings out
    assign measure_enable = run_ok & stby_lo_q[`PSR_READY_BIT] & stby_lo_q[`PSR_BIAS_BIT];
    assign standby_low = stby_lo_q;
    assign standby_high = stby_hi_q;
    assign sense_config_a = cfg_a_q;
    assign sense_config_b = cfg_b_q;
    assign sense_config_c = cfg_c_q;
    assign emitter_current_config = emit_q;
    assign crosstalk_offset = xtalk_q;
    assign autocal_config = acal_q;
    assign low_power_config = lowpow_q;

endmodule : psr_top

// [tb/psr_host_model.sv]
`timescale 1ns/1ps
module psr_host_model (
    // Wire levels seen and pulled by the bus controller
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // 200 ns link period: SDA moves late in the low phase for hold margin
    localparam int LOW_SET = 90;
    localparam int LOW_REST = 30;
    localparam int HIGH_HALF = 40;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic put_bit(input logic b, output logic got);
        #LOW_SET sda_pull = ~b;
        #LOW_REST scl = 1'b1;
        #HIGH_HALF got = sda;
        #HIGH_HALF scl = 1'b0;
    endtask : put_bit

    // Also serves as repeated start, entered with SCL low
    task automatic start_cond;
        #LOW_SET sda_pull = 1'b0;
        #LOW_REST scl = 1'b1;
        #HIGH_HALF sda_pull = 1'b1;
        #HIGH_HALF scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        #LOW_SET sda_pull = 1'b1;
        #LOW_REST scl = 1'b1;
        #HIGH_HALF sda_pull = 1'b0;
        #(2 * HIGH_HALF);
    endtask : stop_cond

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic mack,
                        output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], g);
            rx[i] = g;
        end
        put_bit(~mack, g);
        ack = ~g;
    endtask : xfer

    task automatic wr_word(input logic [6:0] dev, input logic [7:0] cmd, input logic [15:0] d,
                           output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start_cond();
        xfer({dev, 1'b0}, rx, 1'b0, a0);
        xfer(cmd, rx, 1'b0, a1);
        xfer(d[7:0], rx, 1'b0, a2);
        xfer(d[15:8], rx, 1'b0, a3);
        stop_cond();
        ok = a0 & a1 & a2 & a3;
    endtask : wr_word

    task automatic rd_word(input logic [6:0] dev, input logic [7:0] cmd, output logic [15:0] d,
                           output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start_cond();
        xfer({dev, 1'b0}, rx, 1'b0, a0);
        xfer(cmd, rx, 1'b0, a1);
        start_cond();
        xfer({dev, 1'b1}, rx, 1'b0, a2);
        xfer(8'hFF, d[7:0], 1'b1, a3);
        xfer(8'hFF, d[15:8], 1'b0, a3);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : rd_word
endmodule : psr_host_model

// [tb/psr_top_assertions.sv]
`timescale 1ns/1ps
module psr_top_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic int_out,
    input wire logic int_oe,
    // Front end and settings
    input wire logic sample_valid,
    input wire logic measure_enable,
    input wire logic quick_sample_req,
    input wire logic [7:0] standby_low,
    input wire logic [7:0] sense_config_a,
    input wire logic [15:0] crosstalk_offset
);
    logic scl_q;
    logic [3:0] fall_cnt_q;
    logic [3:0] smp_cnt_q;
    logic [5:0] high_cnt_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Saturating ages, so a long quiet spell never aliases into a window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            fall_cnt_q <= 4'hF;
            smp_cnt_q <= 4'hF;
            high_cnt_q <= 6'h00;
        end else begin
            scl_q <= scl_in;
            fall_cnt_q <= (scl_q && !scl_in) ? 4'h0 : fall_cnt_q + 4'(fall_cnt_q != 4'hF);
            smp_cnt_q <= sample_valid ? 4'h0 : smp_cnt_q + 4'(smp_cnt_q != 4'hF);
            high_cnt_q <= !scl_in ? 6'h00 : high_cnt_q + 6'(high_cnt_q != 6'h3F);
        end
    end

    sequence s_mode_off;
        (sense_config_a[3:2] inside {2'b00, 2'b11}) [*2];
    endsequence
    sequence s_quick_off;
        (!sense_config_a[1]) [*2];
    endsequence

    data_od_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
    int_od_a: assert property (int_out == 1'b0) else $error("int pin driven high");
    reset_cfg_a: assert property ($rose(reset_n) |-> standby_low == 8'h01 &&
        sense_config_a == 8'h01 && crosstalk_offset == 16'h0000 && !measure_enable)
        else $error("config not at reset values");
    run_gate_a: assert property (measure_enable ==
        (!sense_config_a[0] && standby_low[7] && standby_low[1])) else $error("run gate wrong");
    irq_off_a: assert property (s_mode_off |-> !int_oe) else $error("int while off");
    irq_cause_a: assert property ($rose(int_oe) |-> smp_cnt_q <= 4'd6)
        else $error("int without sample");
    irq_hold_a: assert property ($fell(int_oe) && sense_config_a[3:2] == 2'b10 &&
        $past(sense_config_a[3:2]) == 2'b10 |-> fall_cnt_q <= 4'd6) else $error("int dropped");
    ack_time_a: assert property ($changed(sda_oe) |-> fall_cnt_q inside {[1:6]})
        else $error("data drive off clock fall");
    idle_free_a: assert property (high_cnt_q > 6'd40 |-> !sda_oe)
        else $error("data held on idle bus");
    quick_off_a: assert property (s_quick_off |-> !quick_sample_req)
        else $error("quick request while disabled");
endmodule : psr_top_checker

bind psr_top psr_top_checker u_psr_top_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .sample_valid(sample_valid),
    .measure_enable(measure_enable), .quick_sample_req(quick_sample_req),
    .standby_low(standby_low), .sense_config_a(sense_config_a),
    .crosstalk_offset(crosstalk_offset)
);

// [tb/tb_psr_top.sv]
`timescale 1ns/1ps
module tb_psr_top;
    localparam logic [7:0] ID_LO = 8'h3C; // Arbitrary identity value
    localparam logic [7:0] ID_HI = 8'h11; // Arbitrary identity value
    logic ref_clk = 1'b0;
    logic reset_n, scl, host_pull, sda_oe, sda_out, int_oe, int_out, sample_valid, ok;
    logic autocal_busy, sunlight_protect, measure_enable, quick_sample_req;
    logic [11:0] sample_data, autocal_value;
    logic [7:0] standby_low, standby_high, sense_a, sense_b, sense_c, emit_cfg, ac_cfg, lp_cfg;
    logic [15:0] xtalk, rd, lo_thr, hi_thr, off;
    int error_cnt = 0;
    int n_tests = 0;
    wire sda;

    // Open drain with pull-up: low if either party pulls
    assign sda = !(host_pull || (sda_oe && !sda_out));
    always #12.5 ref_clk = ~ref_clk;

    psr_top #(.IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI)) u_psr_top (
        .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .sample_valid(sample_valid),
        .sample_data(sample_data), .autocal_value(autocal_value), .autocal_busy(autocal_busy),
        .sunlight_protect(sunlight_protect), .measure_enable(measure_enable),
        .quick_sample_req(quick_sample_req), .standby_low(standby_low),
        .standby_high(standby_high), .sense_config_a(sense_a), .sense_config_b(sense_b),
        .sense_config_c(sense_c), .emitter_current_config(emit_cfg),
        .crosstalk_offset(xtalk), .autocal_config(ac_cfg), .low_power_config(lp_cfg));
    psr_host_model u_psr_host_model (.scl(scl), .sda_pull(host_pull), .sda(sda));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        u_psr_host_model.wr_word(7'h60, c, d, ok);
        check("write ack", ok, 1'b1);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] c, input logic [15:0] exp);
        u_psr_host_model.rd_word(7'h60, c, rd, ok);
        check("read ack", ok, 1'b1);
        check(what, rd, exp);
    endtask : rdc

    task automatic feed(input logic [11:0] s);
        @(negedge ref_clk);
        sample_valid = 1'b1;
        sample_data = s;
        @(negedge ref_clk);
        sample_valid = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask : feed

    // Kind 2 above high, 1 below low; 0 and 3 sit exactly on the high and low bound
    function automatic logic [11:0] pick(input int kind);
        case (kind)
            2: return 12'(hi_thr + off + 16'd1 + 16'($urandom % 64));
            1: return 12'($urandom % (lo_thr + off));
            3: return 12'(lo_thr + off);
            default: return 12'(hi_thr + off);
        endcase
    endfunction : pick

    function automatic logic [15:0] exp_res(input logic [11:0] s);
        return (16'(s) > off) ? 16'(s) - off : 16'h0000;
    endfunction : exp_res

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #1_000_000;
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen timeout");
        give_verdict();
    end

    initial begin
        logic [7:0] codes [11];
        logic [15:0] exps [11];
        logic [11:0] s;
        void'($urandom(32'hFF8BDEE4));
        reset_n = 1'b0;
        sample_valid = 1'b0;
        sample_data = 12'h000;
        autocal_value = 12'($urandom);
        autocal_busy = 1'($urandom);
        sunlight_protect = 1'($urandom);
        codes = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'hF8, 8'hF9, 8'hFA, 8'hFB};
        exps = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, {ID_HI, ID_LO},
            {autocal_busy, sunlight_protect, 2'b00, autocal_value}};
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("config ports", {standby_low, standby_high, sense_a, sense_b, sense_c, emit_cfg,
            ac_cfg, lp_cfg}, 64'h0100_0100_0000_0000);
        for (int i = 0; i < 11; i++) begin
            rdc("reset read", codes[i], exps[i]);
        end
        rdc("unknown code", 8'h42, 16'h0000);
        wr(8'hF8, 16'hFFFF);
        rdc("result after write", 8'hF8, 16'h0000);
        u_psr_host_model.wr_word(7'h61, 8'h05, 16'hFFFF, ok);
        check("foreign address ack", ok, 1'b0);
        rdc("threshold after foreign write", 8'h05, 16'h0000);
        wr(8'h00, 16'h0203);
        wr(8'h00, 16'h0283);
        check("standby ports", {standby_high, standby_low}, 16'h0283);
        for (int i = 1; i < 7; i++) begin
            exps[i] = 16'($urandom);
            if (i == 1) exps[i][7:0] = 8'h01; // Stay stopped with interrupts off
            wr(codes[i], exps[i]);
            rdc("rw readback", codes[i], exps[i]);
        end
        check("config ports", {sense_b, emit_cfg, sense_c, xtalk, lp_cfg, ac_cfg},
            {exps[1][15:8], exps[2], exps[5], exps[6]});
        lo_thr = 16'(100 + $urandom % 50);
        hi_thr = 16'(400 + $urandom % 100);
        off = 16'(1 + $urandom % 63);
        wr(8'h05, lo_thr);
        wr(8'h06, hi_thr);
        wr(8'h07, off);
        wr(8'h03, 16'h0000);
        check("run gate on", measure_enable, 1'b1);
        s = pick(2);
        feed(s);
        rdc("result", 8'hF8, exp_res(s));
        feed(12'(off - 16'd1));
        rdc("result floor", 8'hF8, 16'h0000);
        wr(8'h03, 16'h0001);
        check("run gate off", measure_enable, 1'b0);
        feed(s);
        rdc("result while stopped", 8'hF8, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            wr(8'h03, {8'h00, 4'h0, m[1:0], 2'b00});
            feed(pick(0));
            u_psr_host_model.rd_word(7'h60, 8'hF9, rd, ok);
            feed(pick(2));
            check("int after close", int_oe, m == 1 || m == 2);
            feed(pick(1));
            check("int after away", int_oe, m == 2);
            rdc("flags", 8'hF9, (m == 2) ? 16'h0300 : 16'h0000);
            check("int after flag read", int_oe, 1'b0);
        end
        for (int p = 0; p < 4; p++) begin
            wr(8'h03, {8'h00, 2'b00, p[1:0], 2'b10, p[0], 1'b0});
            for (int r = 0; r < 2; r++) begin
                feed(pick(3 * r));
                repeat (p) feed(pick(2));
                check("int before count", int_oe, 1'b0);
            end
            if (p > 0) check("quick request", quick_sample_req, p[0]);
            feed(pick(2));
            check("int at count", int_oe, 1'b1);
            rdc("close flag", 8'hF9, 16'h0200);
            feed(pick(2));
            check("int once per excursion", int_oe, 1'b0);
        end
        give_verdict();
    end
endmodule : tb_psr_top
